// File: design/adc_sar_control.sv
// Converter control: APB registers, clock divider and SAR sequencer
`timescale 1ns/1ps
module adc_sar_control
	import adc_sar_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wait_mode,
	input wire logic halt_mode,
	input wire logic cmp_above,
	input wire logic [15:0] pin_level,
	output logic analog_power,
	output logic sample_hold,
	output logic [3:0] mux_select,
	output logic [RES_BITS-1:0] dac_code
);

	logic [7:0] csr_reg, csr_next;
	logic [RES_BITS-1:0] result_reg, result_next;
	logic [RES_BITS-1:0] trial_reg, trial_next;
	logic [3:0] bit_reg, bit_next;
	logic [3:0] samp_reg, samp_next;
	logic [1:0] div_reg, div_next;
	logic [7:0] wake_reg, wake_next;
	logic stable_reg, stable_next;
	conv_state_type state_reg, state_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_csr, rd_high, ce, conv_done, chan_change, run;
	result_type res_view;

	// Address decode shared by write and read paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit(paddr, CSR_ADDR) || hit(paddr, HIGH_ADDR)
		|| hit(paddr, LOW_ADDR) || hit(paddr, PWR_ADDR));
	assign wr_csr = psel && penable && pwrite && hit(paddr, CSR_ADDR);
	assign rd_high = psel && penable && !pwrite && hit(paddr, HIGH_ADDR);
	assign chan_change = wr_csr && (pwdata[3:0] != csr_reg[3:0]);
	// Halt powers the core down; wait has no effect
	assign run = csr_reg[ON_BIT] && !halt_mode;
	assign res_view.high_byte = result_reg[9:2];
	assign res_view.low_byte = {6'h00, result_reg[1:0]};

	// Control/status register and end-of-conversion flag
	always_comb begin
		csr_next = csr_reg;
		if (wr_csr) begin
			csr_next[6:0] = pwdata[6:0] & CSR_WMASK[6:0];
			csr_next[EOC_BIT] = 1'b0;
		end else if (rd_high) begin
			csr_next[EOC_BIT] = 1'b0;
		end
		// Completion beats a high-byte read clear; a control write in the same cycle keeps the flag clear
		if (conv_done && !wr_csr && stable_reg) begin
			csr_next[EOC_BIT] = 1'b1;
		end
	end

	// Read mux, registered for the data output
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				CSR_ADDR: rdata_next = {24'h000000, csr_reg};
				HIGH_ADDR: rdata_next = {24'h000000, res_view.high_byte};
				LOW_ADDR: rdata_next = {24'h000000, res_view.low_byte};
				PWR_ADDR: rdata_next = {16'h0000, pin_level};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end
	assign prdata = rdata_reg;

	// Converter clock enable from the CPU clock
	always_comb begin
		div_next = div_reg + 2'h1;
		ce = 1'b0;
		if (div_reg == (csr_reg[SPEED_BIT] ? DIV2_LAST : DIV4_LAST)) begin
			div_next = 2'h0;
			ce = 1'b1;
		end
		if (!run) begin
			div_next = 2'h0;
		end
	end

	// Stabilization timer after power-up or wake
	always_comb begin
		wake_next = wake_reg;
		stable_next = stable_reg;
		if (!run) begin
			wake_next = 8'h00;
			stable_next = 1'b0;
		end else if (!stable_reg) begin
			wake_next = wake_reg + 8'h01;
			stable_next = (wake_reg == WAKE_LAST);
		end
	end

	// Successive approximation sequencer
	always_comb begin
		state_next = state_reg;
		trial_next = trial_reg;
		bit_next = bit_reg;
		samp_next = samp_reg;
		result_next = result_reg;
		conv_done = 1'b0;
		if (!run || chan_change) begin
			// Abort; restart from sampling when still enabled
			state_next = run ? ST_SAMPLE : ST_OFF;
			samp_next = 4'h0;
			trial_next = '0;
		end else begin
			case (state_reg)
				ST_OFF: begin
					state_next = ST_SAMPLE;
					samp_next = 4'h0;
				end
				ST_SAMPLE: if (ce) begin
					samp_next = samp_reg + 4'h1;
					if (samp_reg == SAMPLE_TICKS - 4'h1) begin
						state_next = ST_APPROX;
						bit_next = 4'(RES_BITS - 1);
						trial_next = {1'b1, {(RES_BITS-1){1'b0}}};
					end
				end
				ST_APPROX: if (ce) begin
					// Keep the bit when input is at or above the trial level
					if (!cmp_above) begin
						trial_next[bit_reg] = 1'b0;
					end
					if (bit_reg == 4'h0) begin
						conv_done = 1'b1;
						result_next = trial_next;
						state_next = ST_SAMPLE;
						samp_next = 4'h0;
					end else begin
						bit_next = bit_reg - 4'h1;
						trial_next[bit_reg - 4'h1] = 1'b1;
					end
				end
				default: state_next = ST_OFF;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			csr_reg <= CSR_RESET;
			result_reg <= '0;
			trial_reg <= '0;
			bit_reg <= 4'h0;
			samp_reg <= 4'h0;
			div_reg <= 2'h0;
			wake_reg <= 8'h00;
			stable_reg <= 1'b0;
			state_reg <= ST_OFF;
			rdata_reg <= 32'h0000_0000;
		end else begin
			csr_reg <= csr_next;
			result_reg <= result_next;
			trial_reg <= trial_next;
			bit_reg <= bit_next;
			samp_reg <= samp_next;
			div_reg <= div_next;
			wake_reg <= wake_next;
			stable_reg <= stable_next;
			state_reg <= state_next;
			rdata_reg <= rdata_next;
		end
	end

	// Analog side drives
	assign analog_power = run;
	assign sample_hold = (state_reg == ST_SAMPLE);
	assign mux_select = csr_reg[3:0];
	assign dac_code = trial_reg;

	// Control write leaves flag low next cycle
	property p_eoc_write_clear;
		@(posedge mclk) disable iff (rst) wr_csr |=> !csr_reg[EOC_BIT];
	endproperty
	a_eoc_write_clear: assert property (p_eoc_write_clear) else $error("flag survived write");

	// Low read alone leaves the flag set
	property p_low_keeps;
		@(posedge mclk) disable iff (rst)
		(psel && penable && !pwrite && hit(paddr, LOW_ADDR) && csr_reg[EOC_BIT]) |=> csr_reg[EOC_BIT];
	endproperty
	a_low_keeps: assert property (p_low_keeps) else $error("low read cleared flag");

	// Completion sets flag and stores result
	property p_done_sets;
		@(posedge mclk) disable iff (rst)
		(conv_done && !wr_csr && stable_reg) |=> csr_reg[EOC_BIT] && result_reg == $past(result_next);
	endproperty
	a_done_sets: assert property (p_done_sets) else $error("completion not recorded");

	// Disabled converter is powered down within one cycle
	property p_off_idle;
		@(posedge mclk) disable iff (rst) !run |=> state_reg == ST_OFF;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("converter kept running");

	// Channel change restarts sampling
	property p_chan_restart;
		@(posedge mclk) disable iff (rst)
		(chan_change && run) |=> state_reg == ST_SAMPLE && samp_reg == 4'h0 && !csr_reg[EOC_BIT];
	endproperty
	a_chan_restart: assert property (p_chan_restart) else $error("no restart on channel");

	// Divide by two when speed bit set
	property p_speed_div;
		@(posedge mclk) disable iff (rst)
		(run && csr_reg[SPEED_BIT] && ce && $stable(csr_reg)
		##1 (run && csr_reg[SPEED_BIT] && !wr_csr)) |-> !ce ##1 ce;
	endproperty
	a_speed_div: assert property (p_speed_div) else $error("wrong fast divider");

	// Low register reads never show upper bits
	property p_low_zero;
		@(posedge mclk) disable iff (rst)
		(psel && penable && !pwrite && hit(paddr, LOW_ADDR)) |-> prdata[31:2] == 30'h0;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low upper bits set");

	// Mux follows the channel field
	property p_mux;
		@(posedge mclk) disable iff (rst) wr_csr |=> mux_select == $past(pwdata[3:0]);
	endproperty
	a_mux: assert property (p_mux) else $error("channel not applied");

endmodule

// File: design/adc_sar_pkg.sv
// Shared constants and types for the converter control block
package adc_sar_pkg;
	// Register byte offsets on the APB side
	localparam logic [11:0] CSR_ADDR = 12'h000;
	localparam logic [11:0] HIGH_ADDR = 12'h004;
	localparam logic [11:0] LOW_ADDR = 12'h008;
	localparam logic [11:0] PWR_ADDR = 12'h00C;
	// Control/status field positions
	localparam int EOC_BIT = 7;
	localparam int SPEED_BIT = 6;
	localparam int ON_BIT = 5;
	localparam int RSVD_BIT = 4;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] CSR_WMASK = 8'h7F;
	localparam int RES_BITS = 10;
	// Converter clock dividers
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [1:0] DIV2_LAST = 2'h1;
	// Sampling phase length in converter clocks
	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	// Wake stabilization time in ns and in cycles of the 50 ns clock
	localparam int WAKE_STAB_NS = 1000;
	localparam int CLK_NS = 50;
	localparam int WAKE_STAB_CYCLES = (WAKE_STAB_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] WAKE_LAST = 8'(WAKE_STAB_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_APPROX = 2'b10
	} conv_state_type;

	// Result as presented to software
	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} result_type;
endpackage

// File: verif/analog_front_model.sv
// Behavioural model of the analog multiplexer and comparator
`timescale 1ns/1ps
module analog_front_model
	import adc_sar_pkg::*;
(
	input wire logic mclk,
	input wire logic analog_power,
	input wire logic [3:0] mux_select,
	input wire logic [RES_BITS-1:0] dac_code,
	input wire logic [3:0] bias,
	output logic cmp_above
);
	logic [10:0] lvl;
	logic flip = 1'b0;
	// Input 15 sits above the high reference, input 0 below the low one
	always_comb begin
		lvl = (mux_select == 4'hF) ? 11'h7FF : {1'b0, mux_select, 6'h00} + 11'(bias);
		if (!analog_power) begin
			cmp_above = flip; // Unpowered comparator output is junk, not a steady level
		end else if (mux_select == 4'h0) begin
			cmp_above = 1'b0;
		end else begin
			cmp_above = (lvl >= 11'(dac_code));
		end
	end
	// Toggle source for the unpowered output
	always_ff @(posedge mclk) begin
		flip <= ~flip;
	end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
	import adc_sar_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_data;
	logic pready, pslverr, err_seen, wait_mode = 1'b0, halt_mode = 1'b0, cmp_above;
	logic analog_power, sample_hold;
	logic [15:0] pin_level = 16'hA5C3;
	logic [3:0] mux_select, bias = 4'h5;
	logic [RES_BITS-1:0] dac_code, res;
	int n_mismatch = 0, checks = 0, cyc = 0, t0;
	always #25 mclk = ~mclk;
	adc_sar_control u_adc_sar_control(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wait_mode(wait_mode), .halt_mode(halt_mode), .cmp_above(cmp_above),
		.pin_level(pin_level), .analog_power(analog_power), .sample_hold(sample_hold),
		.mux_select(mux_select), .dac_code(dac_code));
	analog_front_model u_analog_front_model(.mclk(mclk), .analog_power(analog_power),
		.mux_select(mux_select), .dac_code(dac_code), .bias(bias), .cmp_above(cmp_above));
	task finish_test;
		if (n_mismatch == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; answer taken at the edge that sees pready high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the bench timeout ends a stalled wait
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_data, exp);
	endtask
	// Poll the flag with a bounded number of reads
	task wait_eoc;
		int k;
		k = 0;
		do begin
			apb(1'b0, CSR_ADDR, 32'h0);
			k++;
		end while (rd_data[EOC_BIT] !== 1'b1 && k < 200);
		chk(32'(rd_data[EOC_BIT]), 32'h1);
	endtask
	function automatic logic [9:0] exp_res(input logic [3:0] c, input logic [3:0] b);
		if (c == 4'h0) return 10'h000;
		if (c == 4'hF) return 10'h3FF;
		return {c, 6'h00} + 10'(b);
	endfunction
	// Power up on a channel, time the first result, read low then high
	task conv(input logic [3:0] c, input logic sp);
		logic [31:0] v;
		v = {24'h0, 1'b0, sp, 1'b1, 1'b0, c};
		apb(1'b1, CSR_ADDR, 32'h0);
		apb(1'b1, CSR_ADDR, v);
		t0 = cyc;
		repeat (2) @(posedge mclk);
		chk(32'(sample_hold), 32'h1);
		wait_eoc();
		chk(32'((cyc - t0) > 45), 32'(!sp));
		res = exp_res(c, bias);
		rd(LOW_ADDR, {30'h0, res[1:0]});
		rd(CSR_ADDR, v | 32'h80);
		rd(HIGH_ADDR, {24'h0, res[9:2]});
		rd(CSR_ADDR, v);
	endtask
	// Hang guard, far beyond the expected run of under two thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(CSR_ADDR, 32'h0);
		rd(HIGH_ADDR, 32'h0);
		rd(LOW_ADDR, 32'h0);
		rd(12'h010, 32'h0);
		chk(32'(err_seen), 32'h1);
		apb(1'b1, CSR_ADDR, 32'h80);
		rd(CSR_ADDR, 32'h0);
		rd(PWR_ADDR, 32'h0000A5C3);
		for (int i = 0; i < 16; i++) conv(4'(i), i[0]);
		// Continuous running: two results pass unread, the last shows the new input
		apb(1'b1, CSR_ADDR, 32'h23);
		wait_eoc();
		bias <= 4'hA;
		apb(1'b1, CSR_ADDR, 32'h23);
		rd(CSR_ADDR, 32'h23);
		wait_eoc();
		apb(1'b1, CSR_ADDR, 32'h23);
		wait_eoc();
		res = exp_res(4'h3, 4'hA);
		rd(LOW_ADDR, {30'h0, res[1:0]});
		rd(HIGH_ADDR, {24'h0, res[9:2]});
		// Channel change mid-conversion restarts on the new input
		apb(1'b1, CSR_ADDR, 32'h25);
		repeat (30) @(posedge mclk);
		apb(1'b1, CSR_ADDR, 32'h29);
		rd(CSR_ADDR, 32'h29);
		wait_eoc();
		res = exp_res(4'h9, 4'hA);
		rd(HIGH_ADDR, {24'h0, res[9:2]});
		wait_mode <= 1'b1;
		apb(1'b1, CSR_ADDR, 32'h29);
		wait_eoc();
		wait_mode <= 1'b0;
		halt_mode <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(32'(analog_power), 32'h0);
		halt_mode <= 1'b0;
		apb(1'b1, CSR_ADDR, 32'h0);
		@(posedge mclk);
		chk(32'(analog_power), 32'h0);
		repeat (150) @(posedge mclk);
		chk(32'(sample_hold), 32'h0);
		rd(CSR_ADDR, 32'h0);
		finish_test();
	end
endmodule
